// ==== aipc_pkg.sv ====
/*
 Shared constants for the ALS interrupt persistence and calibration configuration block.
 Assumes an 8-bit register port driven by the serial interface decoder.
*/
// Function
// RULE_01: Per-step calibration enable makes calibration iterate per sequencer step.
// RULE_02: Host keeps per-step calibration zero while AGC calibration is enabled.
// RULE_03: Prediction target bit: zero aims at half scale, one at quarter scale.
// RULE_04: Per-step interrupt bit raises sequencer interrupt after every step.
// RULE_05: Power-on rising edge clears oscillator trim unless preserve is set.
// RULE_06: Preserve bit keeps oscillator trim across power-on rising edge.
// RULE_07: Source select 00 picks modulator 0, 01 picks modulator 1.
// RULE_08: Count consecutive out-of-range samples; interrupt when count reaches requirement.
// RULE_09: Any in-range sample resets the persistence counter to zero.
// RULE_10: Code 0 interrupts every cycle, 1 once, 2 and 3 need that many.
// RULE_11: Codes 4 and up need five per step, sixty at code F.
// RULE_12: Persistence counter saturates at the requirement while out of range.
package aipc_pkg;
    localparam logic [7:0] CALIB_SEQ_CFG_ADDR = 8'hA5;
    localparam logic [7:0] ALS_FILT_CFG_ADDR = 8'hA6;
    localparam int STEP_CAL_BIT = 6;
    localparam int TARGET_LVL_BIT = 5;
    localparam int SINT_STEP_BIT = 4;
    localparam int TRIM_KEEP_BIT = 3;
    localparam int SRC_SEL_LSB = 4;
    localparam int PERS_LSB = 0;
    localparam logic [7:0] CALIB_SEQ_CFG_RST = 8'h00;
    localparam logic [7:0] ALS_FILT_CFG_RST = 8'h00;
    localparam logic [7:0] CALIB_SEQ_CFG_MASK = 8'h78;
    localparam logic [7:0] ALS_FILT_CFG_MASK = 8'h3F;
    localparam logic [1:0] SRC_MOD0 = 2'h0;
    localparam logic [1:0] SRC_MOD1 = 2'h1;
    localparam logic [5:0] PERS_STEP = 6'h05;
    localparam logic [3:0] PERS_LINEAR_MAX = 4'h3;
    localparam logic [7:0] TRIM_RST = 8'h00;
endpackage

// ==== aipc_pers_if.sv ====
/*
 Carrier between the configuration top and the persistence filter.
 Assumes a single clock domain.
*/
`timescale 1ns/1ns
interface aipc_pers_if;
    logic [3:0] code;
    logic [15:0] sample;
    logic sample_valid;
    logic [15:0] low_thr;
    logic [15:0] high_thr;
    logic fire;
    logic [5:0] count;
    modport cfg (output code, output sample, output sample_valid, output low_thr,
        output high_thr, input fire, input count);
    modport filt (input code, input sample, input sample_valid, input low_thr,
        input high_thr, output fire, output count);
endinterface

// ==== aipc_pers_filter.sv ====
/*
 Persistence filter: counts consecutive out-of-range ALS samples.
 Assumes sample_valid pulses once per completed ALS cycle.
*/
`timescale 1ns/1ns
module aipc_pers_filter (
    input wire logic clk,
    input wire logic sys_rst,
    aipc_pers_if.filt pif
);
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    logic fire_reg;
    logic fire_next;
    wire logic out_of_range = (pif.sample < pif.low_thr) || (pif.sample > pif.high_thr);
    wire logic [5:0] need = (pif.code <= aipc_pkg::PERS_LINEAR_MAX) ? {2'h0, pif.code}
        : 6'(pif.code - 4'h3) * aipc_pkg::PERS_STEP; // RULE_10 RULE_11
    wire logic [5:0] cnt_inc = (cnt_reg >= need) ? need : cnt_reg + 6'h01; // RULE_12

    always_comb begin
        cnt_next = cnt_reg;
        fire_next = 1'b0;
        if (pif.sample_valid) begin
            if (pif.code == 4'h0) begin
                fire_next = 1'b1; // RULE_10
                cnt_next = 6'h00;
            end else if (!out_of_range) begin
                cnt_next = 6'h00; // RULE_09
            end else begin
                cnt_next = cnt_inc; // RULE_08
                fire_next = (cnt_inc >= need); // RULE_08
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_reg <= 6'h00;
            fire_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            fire_reg <= fire_next;
        end
    end

    assign pif.fire = fire_reg;
    assign pif.count = cnt_reg;
endmodule

// ==== aipc_top.sv ====
/*
 Two configuration registers plus the effects they steer: calibration stepping,
 prediction target, per-step sequencer interrupt, trim clear on power-on,
 threshold source select and the persistence filter.
 Assumes reg_wr/reg_rd are single-cycle strobes from the serial decoder.
*/
`timescale 1ns/1ns
module aipc_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic power_on_control,
    input wire logic trim_wr,
    input wire logic [7:0] trim_wdata,
    output logic [7:0] oscillator_trim_value,
    input wire logic [15:0] mod0_data,
    input wire logic [15:0] mod1_data,
    input wire logic als_sample_valid,
    input wire logic [15:0] als_low_threshold,
    input wire logic [15:0] als_high_threshold,
    output logic als_interrupt,
    output logic [5:0] persistence_count,
    input wire logic seq_step_done,
    input wire logic seq_round_done,
    output logic sequencer_system_interrupt,
    input wire logic calib_nth_tick,
    input wire logic calib_round_tick,
    output logic calib_start,
    output logic agc_quarter_target
);
    logic [7:0] calib_cfg_reg;
    logic [7:0] filt_cfg_reg;
    logic [7:0] trim_reg;
    logic [7:0] trim_next;
    logic pon_reg;
    logic [7:0] rdata_reg;
    logic sint_reg;
    logic cal_reg;
    logic tgt_reg;
    logic [15:0] sample_reg;
    logic valid_reg;

    aipc_pers_if pif();

    wire logic sel_calib = (reg_addr == aipc_pkg::CALIB_SEQ_CFG_ADDR);
    wire logic sel_filt = (reg_addr == aipc_pkg::ALS_FILT_CFG_ADDR);
    wire logic step_cal_en = calib_cfg_reg[aipc_pkg::STEP_CAL_BIT];
    wire logic sint_step_en = calib_cfg_reg[aipc_pkg::SINT_STEP_BIT];
    wire logic trim_preserve = calib_cfg_reg[aipc_pkg::TRIM_KEEP_BIT];
    wire logic [1:0] threshold_source_select = filt_cfg_reg[aipc_pkg::SRC_SEL_LSB +: 2];
    wire logic [3:0] als_persistence_count = filt_cfg_reg[aipc_pkg::PERS_LSB +: 4];
    wire logic pon_rise = power_on_control && !pon_reg;
    // Reserved codes 10 and 11 fall back to modulator 0
    wire logic [15:0] sel_sample = (threshold_source_select == aipc_pkg::SRC_MOD1)
        ? mod1_data : mod0_data; // RULE_07
    wire logic [7:0] rd_mux = sel_calib ? calib_cfg_reg : (sel_filt ? filt_cfg_reg : 8'h00);

    wire logic wr_calib = reg_wr && sel_calib;
    wire logic wr_filt = reg_wr && sel_filt;
    wire logic trim_clear = pon_rise && !trim_preserve; // RULE_05 RULE_06
    wire logic sint_src = sint_step_en ? seq_step_done : seq_round_done; // RULE_04
    // Host must hold step_cal_en low while AGC calibration runs
    wire logic cal_src = step_cal_en ? calib_nth_tick : calib_round_tick; // RULE_01 RULE_02
    wire logic tgt_src = calib_cfg_reg[aipc_pkg::TARGET_LVL_BIT]; // RULE_03

    // Write port has priority over clear so a fresh trim is never lost
    always_comb begin
        trim_next = trim_reg;
        if (trim_wr) begin
            trim_next = trim_wdata;
        end else if (trim_clear) begin
            trim_next = aipc_pkg::TRIM_RST; // RULE_05 RULE_06
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            calib_cfg_reg <= aipc_pkg::CALIB_SEQ_CFG_RST;
        end else if (wr_calib) begin
            calib_cfg_reg <= reg_wdata & aipc_pkg::CALIB_SEQ_CFG_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            filt_cfg_reg <= aipc_pkg::ALS_FILT_CFG_RST;
        end else if (wr_filt) begin
            filt_cfg_reg <= reg_wdata & aipc_pkg::ALS_FILT_CFG_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trim_reg <= aipc_pkg::TRIM_RST;
        end else begin
            trim_reg <= trim_next;
        end
    end

    // Previous level kept so only a rising power-on edge clears the trim
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pon_reg <= 1'b0;
        end else begin
            pon_reg <= power_on_control;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            rdata_reg <= rd_mux;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sint_reg <= 1'b0;
        end else begin
            sint_reg <= sint_src; // RULE_04
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cal_reg <= 1'b0;
        end else begin
            cal_reg <= cal_src; // RULE_01
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tgt_reg <= 1'b0;
        end else begin
            tgt_reg <= tgt_src; // RULE_03
        end
    end

    // Sample registered so the filter sees a stable selected channel
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sample_reg <= 16'h0000;
        end else begin
            sample_reg <= sel_sample; // RULE_07
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= als_sample_valid;
        end
    end

    assign pif.code = als_persistence_count;
    assign pif.sample = sample_reg;
    assign pif.sample_valid = valid_reg;
    assign pif.low_thr = als_low_threshold;
    assign pif.high_thr = als_high_threshold;

    aipc_pers_filter u_filt (
        .clk(clk),
        .sys_rst(sys_rst),
        .pif(pif)
    );

    assign reg_rdata = rdata_reg;
    assign oscillator_trim_value = trim_reg;
    assign als_interrupt = pif.fire;
    assign persistence_count = pif.count;
    assign sequencer_system_interrupt = sint_reg;
    assign calib_start = cal_reg;
    assign agc_quarter_target = tgt_reg;
endmodule

// ==== aipc_properties.sv ====
/* Port checker for aipc_top.
 Assumes a bind onto aipc_top, one clock, synchronous reset. */
`timescale 1ns/1ns
module aipc_properties (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic power_on_control,
    input wire logic trim_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] oscillator_trim_value,
    input wire logic seq_step_done,
    input wire logic sequencer_system_interrupt,
    input wire logic calib_nth_tick,
    input wire logic calib_start,
    input wire logic agc_quarter_target,
    input wire logic als_sample_valid,
    input wire logic als_interrupt,
    input wire logic [5:0] persistence_count
);
    logic [7:0] c4, c5, rd_exp;
    assign rd_exp = reg_addr == 8'hA5 ? c4 : reg_addr == 8'hA6 ? c5 : 8'h00;
    // Shadow copies keep reserved bits at zero
    always_ff @(posedge clk) begin
        c4 <= sys_rst ? 8'h00 : reg_wr && reg_addr == 8'hA5 ? reg_wdata & 8'h78 : c4;
        c5 <= sys_rst ? 8'h00 : reg_wr && reg_addr == 8'hA6 ? reg_wdata & 8'h3F : c5;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence cfg_settled; $stable(c4) [*2]; endsequence
    sequence pon_rise; $rose(power_on_control) && !trim_wr; endsequence
    a_read_back: assert property (reg_rd && !reg_wr |=> reg_rdata == $past(rd_exp))
        else $error("read data wrong");
    a_target_level: assert property (cfg_settled |-> agc_quarter_target == c4[5])
        else $error("target level wrong");
    a_trim_clear: assert property (pon_rise ##0 !c4[3] |=> oscillator_trim_value == 8'h00)
        else $error("trim not cleared");
    a_trim_keep: assert property (pon_rise ##0 c4[3] |=> $stable(oscillator_trim_value))
        else $error("trim lost");
    a_step_sint: assert property (seq_step_done && c4[4] |=> sequencer_system_interrupt)
        else $error("step interrupt missing");
    a_cal_step: assert property (calib_nth_tick && c4[6] |=> calib_start)
        else $error("step calibration missing");
    a_fire_cause: assert property (als_interrupt |-> $past(als_sample_valid, 2))
        else $error("interrupt without sample");
    a_count_cap: assert property (persistence_count <= 6'h3C)
        else $error("count above cap");
endmodule

// ==== aipc_als_src.sv ====
/* Sample source standing in for the modulators.
 Assumes the bench thresholds 0x64 and 0xC8. */
`timescale 1ns/1ns
module aipc_als_src (
    input wire logic clk,
    input wire logic fire,
    input wire logic out_rng,
    input wire logic chan,
    output logic [15:0] mod0_data,
    output logic [15:0] mod1_data,
    output logic als_sample_valid
);
    logic [15:0] junk_reg = 16'h0000;
    logic [15:0] hit, miss;
    // Data between samples churns so stale values cannot pass
    always_ff @(posedge clk) junk_reg <= junk_reg + 16'h1357;
    assign hit = out_rng ? 16'h0032 : 16'h0096;
    assign miss = out_rng ? 16'h0096 : 16'h0032;
    assign als_sample_valid = fire;
    assign mod0_data = !fire ? junk_reg : chan ? miss : hit;
    assign mod1_data = !fire ? junk_reg : chan ? hit : miss;
endmodule

// ==== tb_top.sv ====
/* Self-checking bench for aipc_top.
 Assumes the package, interface, design and source model compile first. */
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, trim_wr = 1'b0, ch;
    logic power_on_control = 1'b0, seq_step_done = 1'b0, seq_round_done = 1'b0;
    logic calib_nth_tick = 1'b0, calib_round_tick = 1'b0, fire = 1'b0, out_rng = 1'b0;
    logic chan = 1'b0, als_sample_valid, als_interrupt, sequencer_system_interrupt;
    logic calib_start, agc_quarter_target;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, trim_wdata = 8'h00;
    logic [7:0] reg_rdata, oscillator_trim_value;
    logic [15:0] mod0_data, mod1_data, als_low_threshold = 16'h0064, als_high_threshold = 16'h00C8;
    logic [5:0] persistence_count, n;
    logic [3:0] c;
    logic [3:0] codes [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hF};
    int fails = 0, compares = 0, rv;
    always #10 clk = ~clk;
    aipc_top uut (.*);
    aipc_als_src src (.*);
    function automatic logic [5:0] need(input logic [3:0] k);
        return k <= 4'h3 ? {2'h0, k} : 6'(k - 4'h3) * 6'h05;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk) reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk) reg_rd <= 1'b0;
        @(posedge clk) #1 `CHK("reg_rdata", e, reg_rdata)
        @(posedge clk);
    endtask
    task automatic samp(input logic o, input logic ei, input logic [5:0] ec);
        fire <= 1'b1;
        out_rng <= o;
        @(posedge clk) fire <= 1'b0;
        // Interrupt is a one-cycle pulse two edges after the sample
        @(posedge clk) #1 `CHK("als_interrupt", ei, als_interrupt)
        if (c != 4'h0) `CHK("persistence_count", ec, persistence_count)
        @(posedge clk);
    endtask
    task automatic trim_case(input logic keep);
        logic [7:0] d;
        d = 8'($urandom_range(255, 1));
        wr(8'hA5, {4'h0, keep, 3'h0});
        trim_wdata <= d;
        trim_wr <= 1'b1;
        @(posedge clk) trim_wr <= 1'b0;
        power_on_control <= 1'b1;
        repeat (2) @(posedge clk);
        #1 `CHK("trim", keep ? d : 8'h00, oscillator_trim_value)
        @(posedge clk) power_on_control <= 1'b0;
    endtask
    task automatic wrap_up;
        $display("counts: compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        rv = $urandom(32'hEDB2A020);
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'hA5, 8'h00);
        rd(8'hA6, 8'h00);
        wr(8'hA5, 8'hFF);
        rd(8'hA5, 8'h78);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rv = $urandom;
            wr(8'hA6, rv[7:0]);
            rd(8'hA6, rv[7:0] & 8'h3F);
        end
        $display("test registers done");
        trim_case(1'b0);
        trim_case(1'b1);
        $display("test trim done");
        for (int m = 0; m < 4; m++) begin
            // No AGC calibration path here, so step calibration may be set
            wr(8'hA5, {1'b0, m[1], m[0], m[0], 4'h0});
            seq_step_done <= 1'b1;
            calib_nth_tick <= 1'b1;
            @(posedge clk) seq_step_done <= 1'b0;
            calib_nth_tick <= 1'b0;
            #1 `CHK("sint", m[0], sequencer_system_interrupt)
            `CHK("calib_start", m[1], calib_start)
            `CHK("agc_target", m[0], agc_quarter_target)
            @(posedge clk) seq_round_done <= 1'b1;
            calib_round_tick <= 1'b1;
            @(posedge clk) seq_round_done <= 1'b0;
            calib_round_tick <= 1'b0;
            #1 `CHK("sint_round", !m[0], sequencer_system_interrupt)
            `CHK("calib_round", !m[1], calib_start)
            @(posedge clk);
        end
        $display("test sequencer done");
        for (int i = 0; i < 7; i++) begin
            c = i == 6 ? 4'($urandom_range(15)) : codes[i];
            ch = 1'(i);
            chan <= ch;
            wr(8'hA6, {3'h0, ch, c});
            n = need(c);
            samp(1'b0, c == 4'h0, 6'h00);
            for (int k = 1; k <= n + 1; k++)
                samp(1'b1, k >= n, k > n ? n : 6'(k));
            $display("test persistence code %0h done", c);
        end
        wrap_up();
    end
    initial begin
        repeat (50000) @(posedge clk);
        fails++;
        wrap_up();
    end
endmodule
bind aipc_top aipc_properties chk (.*);
